// ### ldw_watchdog.v
// loop detection watchdog: mode register, restart key, counter and reset request
// assumes a byte-wide CPU bus synchronous to clk; bitOp marks 1-bit manipulation
//
// Summary of operation
// - counter overflow requests a full chip internal reset.
// - watchdog reset sets reset-cause flag bit 4.
// - non-stoppable option always counts slow oscillator, never halted.
// - after reset counting starts at once, slow clock, interval 111.
// - clock select 00 slow, 01 fast, 1x stops the watchdog.
// - interval n overflows after 2^(11+n) slow or 2^(13+n) fast ticks.
// - reset loads mode register with 67H.
// - one mode write allowed; second one resets, deferred while source stopped.
// - non-stoppable option ignores written clock-select field.
// - once stopped the watchdog stays stopped, no reset from rewriting.
// - writing ACH to restart key clears counter and keeps counting.
// - any other key value resets, deferred while source stopped.
// - bit access to restart key resets, deferred while source stopped.
// - restart key always reads 9AH.
// - while stopped by clock select, violations cause no reset.
// - fast source pauses when fast clock stopped, standby, stabilising.
// - slow source pauses in standby or when slow osc turned off while CPU runs on fast clock.
// - each mode write inserts one bus wait cycle.
// - first mode write clears the counter.
// - counter keeps its value across standby pauses.
`timescale 1ns/1ps
`include "ldw_regs.vh"
module ldw_watchdog #(
  parameter CNT_W = `LDW_CNT_W
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       clkEn,
  input  wire       canStop,
  input  wire       slowTick,
  input  wire       fastTick,
  input  wire       standby,
  input  wire       fastHold,
  input  wire       slowOff,
  input  wire       cpuOnFast,
  input  wire [15:0] addr,
  input  wire       wr,
  input  wire       rd,
  input  wire       bitOp,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata,
  output reg        busWait,
  output reg        chipReset,
  output reg        causeFlag
);
  reg  [7:0]       mode_q;
  reg              modeWritten_q;
  reg              stopLatch_q;
  reg              pending_q;
  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] cnt_d;
  reg  [7:0]       rdata_d;
  wire             srcRun;
  wire             tick;
  wire             useFast;
  wire             stopped;
  wire             modeHit;
  wire             keyHit;
  wire             violation;
  wire             overflow;
  wire [4:0]       ovlBit;

  // option fixed from outside; fixed part ignores clock select
  assign useFast = canStop && !mode_q[`LDW_CSEL_HI] && mode_q[`LDW_CSEL_LO];
  assign stopped = canStop && stopLatch_q;
  assign modeHit = wr && (addr == `LDW_MODE_ADDR);
  assign keyHit  = (wr || rd) && (addr == `LDW_KEY_ADDR);
  // key write with wrong value, bit access to key, second mode write
  assign violation = (modeHit && modeWritten_q) ||
                     (keyHit && bitOp) ||
                     (keyHit && wr && wdata != `LDW_KEY_RESTART);
  assign ovlBit = (useFast ? 5'd`LDW_FAST_BASE : 5'd`LDW_SLOW_BASE) +
                  {2'h0, mode_q[`LDW_IVL_MSB:0]};
  assign overflow = tick && (cnt_q[ovlBit[4:0]] == 1'b0) &&
                    (&(cnt_q | ~((({{(CNT_W-1){1'b0}}, 1'b1}) << ovlBit) -
                                  {{(CNT_W-1){1'b0}}, 1'b1})));

  // fixed option never pauses: standby and osc-off only count when stoppable
  ldw_tick_sel u_tick (
    .slowTick  (slowTick),
    .fastTick  (fastTick),
    .useFast   (useFast),
    .stopped   (stopped),
    .standby   (standby && canStop),
    .fastHold  (fastHold && canStop),
    .slowOff   (slowOff && canStop),
    .cpuOnFast (cpuOnFast),
    .srcRun    (srcRun),
    .tick      (tick)
  );

  always @* begin
    cnt_d = cnt_q;
    if ((modeHit && !modeWritten_q) || (keyHit && wr && !bitOp && wdata == `LDW_KEY_RESTART))
      cnt_d = {CNT_W{1'b0}};
    else if (tick)
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  always @* begin
    rdata_d = 8'h00;
    if (rd && addr == `LDW_MODE_ADDR)
      rdata_d = mode_q;
    else if (rd && addr == `LDW_KEY_ADDR)
      rdata_d = `LDW_KEY_READ;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q        <= `LDW_MODE_RESET;
      modeWritten_q <= 1'b0;
      stopLatch_q   <= 1'b0;
      pending_q     <= 1'b0;
      cnt_q         <= {CNT_W{1'b0}};
      rdata         <= 8'h00;
      busWait       <= 1'b0;
      chipReset     <= 1'b0;
      causeFlag     <= 1'b0;
    end else if (clkEn) begin
      cnt_q   <= cnt_d;
      rdata   <= rdata_d;
      busWait <= modeHit;
      if (modeHit && !modeWritten_q) begin
        modeWritten_q <= 1'b1;
        // bits 7..5 forced to 011 regardless of written value
        mode_q <= {`LDW_FIXED_BITS, (canStop ? wdata[4:3] : 2'h0), wdata[2:0]};
        if (canStop && wdata[`LDW_CSEL_HI])
          stopLatch_q <= 1'b1;
      end
      // stopped by clock select: violations dropped
      if (violation && !stopped)
        pending_q <= 1'b1;
      if ((overflow || ((violation || pending_q) && srcRun)) && !stopped) begin
        chipReset <= 1'b1;
        causeFlag <= 1'b1;
      end
    end
  end
endmodule // ldw_watchdog

// ### ldw_regs.vh
// register offsets, field positions, reset values and key codes of the loop watchdog
// assumes an 8-bit peripheral bus with byte addresses
`ifndef LDW_REGS_VH
`define LDW_REGS_VH
`define LDW_MODE_ADDR      16'hff98
`define LDW_KEY_ADDR       16'hff99
`define LDW_MODE_RESET     8'h67
`define LDW_KEY_READ       8'h9a
`define LDW_KEY_RESTART    8'hac
`define LDW_FIXED_BITS     3'h3
`define LDW_CSEL_HI        4
`define LDW_CSEL_LO        3
`define LDW_IVL_MSB        2
`define LDW_CAUSE_BIT      4
`define LDW_SLOW_BASE      11
`define LDW_FAST_BASE      13
`define LDW_CNT_W          21
`endif

// ### ldw_tick_sel.v
// selects and gates the counting tick of the loop watchdog
// assumes the tick inputs are one-cycle enables synchronous to clk
`timescale 1ns/1ps
module ldw_tick_sel (
  input  wire slowTick,
  input  wire fastTick,
  input  wire useFast,
  input  wire stopped,
  input  wire standby,
  input  wire fastHold,
  input  wire slowOff,
  input  wire cpuOnFast,
  output wire srcRun,
  output wire tick
);
  // source clock halted: standby, fast clock stopped or stabilising, slow osc off while CPU on fast clock
  assign srcRun = !stopped && !standby &&
                  (useFast ? !fastHold : !(slowOff && cpuOnFast));
  assign tick   = srcRun && (useFast ? fastTick : slowTick);
endmodule // ldw_tick_sel

// ### ldw_cpu_model.sv
// cpu bus model: one byte access per call
// assumes calls start just after a falling edge
`timescale 1ns/1ps
module ldw_cpu_model (
  input  wire        clk,
  input  wire [7:0]  rdata,
  input  wire        busWait,
  output reg  [15:0] addr = 16'h0000,
  output reg         wr = 0,
  output reg         rd = 0,
  output reg         bitOp = 0,
  output reg  [7:0]  wdata = 8'h00
);
  task acc(input w, b, input [15:0] a, input [7:0] d, output [8:0] q);
    {addr, wr, rd, bitOp, wdata} = {a, w, !w, b, d};
    @(negedge clk);
    q = {busWait, rdata};
    {addr, wr, rd, bitOp, wdata} = {~a, 3'h0, ~d};
    @(negedge clk);
  endtask
endmodule // ldw_cpu_model

// ### ldw_watchdog_chk.sv
// port assertions for the loop watchdog
// assumes one clock domain
`timescale 1ns/1ps
module ldw_watchdog_chk (
  input wire clk, resetn, clkEn, canStop, standby, slowOff, wr, rd, bitOp,
  input wire [15:0] addr,
  input wire [7:0] wdata, rdata,
  input wire busWait, chipReset, causeFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire keyW = clkEn && wr && addr == 16'hff99;
  wire live = !canStop && !standby && !slowOff;
  chk_key_read: assert property (clkEn && rd && addr == 16'hff99 |=> rdata == 8'h9a)
    else $error("key read");
  chk_read_idle: assert property (clkEn && !rd |=> rdata == 8'h00)
    else $error("idle rdata");
  chk_mode_wait: assert property (clkEn && wr && addr == 16'hff98 |=> busWait)
    else $error("no wait");
  chk_wait_cause: assert property (busWait |-> $past(wr) && $past(addr) == 16'hff98)
    else $error("stray wait");
  chk_reset_hold: assert property (chipReset |=> chipReset)
    else $error("reset dropped");
  chk_cause_flag: assert property (chipReset |-> causeFlag)
    else $error("no cause");
  chk_bad_key: assert property (keyW && live && (bitOp || wdata != 8'hac) |=> chipReset)
    else $error("bad key");
  chk_good_key: assert property (keyW && !bitOp && wdata == 8'hac && !chipReset |=> !chipReset)
    else $error("good key");
  cover property ($rose(chipReset));
  cover property (busWait);
  cover property (keyW && wdata == 8'hac);
endmodule // ldw_watchdog_chk
bind ldw_watchdog ldw_watchdog_chk chk (.*);

// ### loop_detect_watchdog_tb.sv
// bench for the loop watchdog
// assumes ldw_cpu_model drives the bus
`timescale 1ns/1ps
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, v); end end
module loop_detect_watchdog_tb;
  reg clk = 0, resetn = 0, clkEn = 1, canStop = 0, slowTick = 1, fastTick = 1;
  reg standby = 0, fastHold = 0, slowOff = 0, cpuOnFast = 0;
  wire [15:0] addr;
  wire [7:0] wdata, rdata;
  wire wr, rd, bitOp, busWait, chipReset, causeFlag;
  reg [8:0] q;
  int num_errors = 0, tests_run = 0, cyc = 0;
  ldw_watchdog uut (.*);
  ldw_cpu_model cpu (.*);
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cyc > 5000) begin num_errors++; results; end
  task results;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task rst(input s);
    canStop = s;
    resetn = 0;
    repeat (6) @(negedge clk);
    resetn = 1;
  endtask
  task wrk(input [15:0] a, input [7:0] d);
    cpu.acc(1, 0, a, d, q);
  endtask
  task isRst(input e);
    @(negedge clk);
    `CHK("chipReset", e, chipReset)
  endtask
  initial begin
    rst(0);
    cpu.acc(0, 0, 16'hff99, 0, q); `CHK("key", 8'h9a, q[7:0])
    cpu.acc(0, 0, 16'hff98, 0, q); `CHK("mode", 8'h67, q[7:0])
    wrk(16'hff98, 8'h60); `CHK("busWait", 1'b1, q[8])
    wrk(16'hff99, 8'hac);
    repeat (2000) @(negedge clk); `CHK("early", 1'b0, chipReset)
    repeat (60) @(negedge clk); `CHK("ovf", 2'b11, {chipReset, causeFlag})
    rst(0); wrk(16'hff99, 8'h55); isRst(1);
    rst(0); cpu.acc(1, 1, 16'hff99, 8'hac, q); isRst(1);
    rst(0); wrk(16'hff98, 8'h67); wrk(16'hff98, 8'h67); isRst(1);
    rst(1); standby = 1; wrk(16'hff99, 8'h55); isRst(0);
    standby = 0; repeat (3) @(negedge clk); isRst(1);
    rst(0); standby = 1; wrk(16'hff99, 8'h55); isRst(1); standby = 0;
    rst(1); fastHold = 1; wrk(16'hff98, 8'h68); wrk(16'hff99, 8'h55); isRst(0);
    fastHold = 0; isRst(1);
    rst(1); wrk(16'hff98, 8'h70); wrk(16'hff98, 8'h60);
    wrk(16'hff99, 8'h55); isRst(0);
    results;
  end
endmodule // loop_detect_watchdog_tb
